// ==== src/ssc_mode_controller.sv ====
`timescale 1ns/100ps
module ssc_mode_controller import ssc_pkg::*; #(
  parameter int RST_HOLD_CYCLES = RST_HOLD_CYC,
  parameter int ACT_DELAY_CYCLES = ACT_DELAY_CYC,
  parameter int OV_DET_CYCLES = OV_DET_CYC,
  parameter logic [7:0] NV_A_RESET = 8'h00,
  parameter logic [7:0] NV_B_RESET = 8'h00,
  parameter logic [7:0] ID0_VALUE = 8'h5a, // arbitrary value
  parameter logic [7:0] ID1_VALUE = 8'ha5 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic csn,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  input wire logic batAbovePon,
  input wire logic batBelowPoff,
  input wire logic smpsBelowPoff,
  input wire logic tempAboveAct,
  input wire logic tempBelowRel,
  input wire logic batOverVolt,
  input wire logic tempWarn,
  input wire logic cpuResetIn,
  output logic cpuResetOut,
  output logic cpuResetOe,
  input wire logic resetEvent,
  input wire logic wakeEvent,
  input wire logic intPending,
  input wire logic wakePending,
  input wire logic wakeSrcEnabled,
  input wire logic [7:0] watchdogStatus,
  output logic limpOut,
  output logic limpOe,
  output logic mainRegEn,
  output logic auxRegEn,
  output logic smpsEn,
  output logic canEn,
  output logic linEn,
  output logic batMonEn,
  output logic hvioEn,
  output logic hvioLsEn,
  output logic hvioFailSafe,
  output logic busHighZ,
  output logic watchdogEn,
  output logic irqClearAll,
  output logic irqEnableAll,
  output logic otWarnIrq,
  output logic ovWarnIrq,
  output logic [4:0] resetSource
);
  localparam int TMAX = (1 << TIMER_W) - 2;
  if (RST_HOLD_CYCLES < 1 || RST_HOLD_CYCLES > TMAX || ACT_DELAY_CYCLES < 1 ||
      ACT_DELAY_CYCLES > TMAX || OV_DET_CYCLES < 1 || OV_DET_CYCLES > TMAX) begin : gChk
    $error("timer parameter out of range");
  end
  localparam logic [TIMER_W-1:0] HOLD_T = RST_HOLD_CYCLES[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] ACT_T = ACT_DELAY_CYCLES[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] OV_T = OV_DET_CYCLES[TIMER_W-1:0];

  ssc_state_type state_q, state_d;
  logic [TIMER_W-1:0] stateTimer_q, ovTimer_q;
  logic [1:0] rcnt_q;
  logic ovf_q, fnPending_q, limpCtl_q, auxCtl_q;
  logic [7:0] nvA_q, nvB_q, rdData_q;
  logic [4:0] rss_q, rssNext;
  logic rdTgl_q, frameSeen_q, tempWarn_q, ovFlag_q;
  logic enterReset;
  logic [7:0] pinS;
  logic frameTglS;

  ssc_spi_if spiBus ();
  ssc_spi_port uSpi (.sck(sck), .csn(csn), .reset_n(reset_n), .sdi(sdi), .sdo(sdo),
    .bus(spiBus.link));

  // analog detector flags and the reset pin come from outside this clock
  ssc_sync2 #(.WIDTH(8)) uPinSync (.clk(clk),
    .din({batAbovePon, batBelowPoff, smpsBelowPoff, tempAboveAct, tempBelowRel,
          batOverVolt, tempWarn, cpuResetIn}),
    .dout(pinS));
  ssc_sync2 #(.WIDTH(1)) uFrameSync (.clk(clk), .din(spiBus.frameTgl), .dout(frameTglS));

  logic ponS, powerOff, otS, relS, ovS, warnS, rstLineHigh;
  assign ponS = pinS[7];
  assign powerOff = pinS[6] && pinS[5];
  assign otS = pinS[4];
  assign relS = pinS[3];
  assign ovS = pinS[2];
  assign warnS = pinS[1];
  assign rstLineHigh = pinS[0];

  // frame decode; word is stable once its toggle has crossed over
  logic frameEv, frameRo, wrOk, rdOk, isFn;
  logic [6:0] frameAddr;
  logic [7:0] frameData;
  assign frameEv = frameTglS != frameSeen_q;
  assign frameAddr = spiBus.frameWord[FRAME_W-1:FR_ADDR_LSB];
  assign frameRo = spiBus.frameWord[FR_RO_BIT];
  assign frameData = spiBus.frameWord[7:0];
  assign isFn = state_q == ST_FNORMAL;
  always_comb begin
    unique case (frameAddr)
      ADDR_MAIN_STATUS, ADDR_WD_STATUS, ADDR_ID_0, ADDR_ID_1: rdOk = 1'b1;
      ADDR_NV_CONFIG_A, ADDR_NV_CONFIG_B: rdOk = 1'b1;
      default: rdOk = !isFn;
    endcase
  end
  assign wrOk = frameEv && !frameRo &&
    (!isFn || frameAddr == ADDR_NV_CONFIG_A || frameAddr == ADDR_NV_CONFIG_B);

  logic cmdValid, nvWrite, sleepDis, sleepOk, cmdSleep, cmdNormal, cmdStandby, ovLong;
  assign cmdValid = wrOk && frameAddr == ADDR_MODE_CTRL;
  assign nvWrite = wrOk && (frameAddr == ADDR_NV_CONFIG_A || frameAddr == ADDR_NV_CONFIG_B);
  assign sleepDis = nvA_q[NVA_SLEEP_DIS_BIT];
  assign sleepOk = !intPending && !wakePending && wakeSrcEnabled;
  assign cmdSleep = cmdValid && frameData[2:0] == MODE_SLEEP && !sleepDis;
  assign cmdNormal = cmdValid && frameData[2:0] == MODE_NORMAL;
  assign cmdStandby = cmdValid && frameData[2:0] == MODE_STANDBY;
  assign ovLong = ovTimer_q > OV_T;
  logic extReset;
  assign extReset = resetEvent || !rstLineHigh;

  // next mode: off first, then overload, then everything else
  always_comb begin
    state_d = state_q;
    enterReset = 1'b0;
    rssNext = RSS_EXTERNAL;
    if (powerOff && state_q != ST_OFF) begin
      state_d = ST_OFF;
    end else if (state_q != ST_OFF && state_q != ST_OVERLOAD && (otS || ovLong)) begin
      state_d = ST_OVERLOAD;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          if (ponS) begin
            state_d = ST_RESET;
            enterReset = 1'b1;
            rssNext = RSS_POWER_ON;
          end
        end
        ST_RESET: begin
          if (ovf_q) begin
            state_d = ST_FSP;
          end else if (stateTimer_q >= HOLD_T && rstLineHigh) begin
            state_d = fnPending_q ? ST_FNORMAL : ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (extReset) begin
            state_d = ST_RESET;
            enterReset = 1'b1;
          end else if (cmdNormal) begin
            state_d = ST_NORMAL;
          end else if (cmdSleep) begin
            state_d = sleepOk ? ST_SLEEP : ST_RESET;
            enterReset = !sleepOk;
            rssNext = RSS_ILLEGAL_SLEEP;
          end
        end
        ST_NORMAL: begin
          if (extReset) begin
            state_d = ST_RESET;
            enterReset = 1'b1;
          end else if (cmdStandby) begin
            state_d = ST_STANDBY;
          end else if (cmdSleep) begin
            state_d = sleepOk ? ST_SLEEP : ST_RESET;
            enterReset = !sleepOk;
            rssNext = RSS_ILLEGAL_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wakeEvent) begin
            state_d = ST_RESET;
            enterReset = 1'b1;
            rssNext = RSS_WAKE;
          end
        end
        ST_OVERLOAD: begin
          if (relS && !ovS) begin
            state_d = ST_RESET;
            enterReset = 1'b1;
            rssNext = RSS_OVERLOAD;
          end
        end
        ST_FSP: begin
          state_d = sleepDis ? ST_RESET : ST_SLEEP;
          enterReset = sleepDis;
          rssNext = RSS_FSP_RETURN;
        end
        ST_FNORMAL: begin
          if (nvWrite) begin
            state_d = ST_RESET;
            enterReset = 1'b1;
            rssNext = RSS_FNORMAL_EXIT;
          end
        end
      endcase
    end
  end

  // mode register and the time spent in the current mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
      stateTimer_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        stateTimer_q <= '0;
      end else if (stateTimer_q != '1) begin
        stateTimer_q <= stateTimer_q + 1'b1;
      end
    end
  end

  // overvoltage must persist; any dropout restarts the measurement
  always_ff @(posedge clk) begin
    if (!reset_n || !ovS) begin
      ovTimer_q <= '0;
    end else if (ovTimer_q <= OV_T) begin
      ovTimer_q <= ovTimer_q + 1'b1;
    end
  end

  // reset counter; power-on starts it from zero, overflow is judged at entry
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rcnt_q <= 2'h0;
      ovf_q <= 1'b0;
      rss_q <= RSS_POWER_ON;
      fnPending_q <= 1'b0;
    end else if (state_q == ST_FSP) begin
      rcnt_q <= 2'h0;
      ovf_q <= 1'b0;
      if (enterReset) begin
        rss_q <= rssNext;
      end
    end else if (enterReset) begin
      rss_q <= rssNext;
      if (state_q == ST_OFF) begin
        rcnt_q <= 2'h0;
        ovf_q <= 1'b0;
        fnPending_q <= nvA_q[NVA_FNORMAL_BIT];
      end else begin
        ovf_q <= rcnt_q == RCC_MAX;
        if (rcnt_q != RCC_MAX) begin
          rcnt_q <= rcnt_q + 2'h1;
        end
      end
    end else if (state_q == ST_RESET && state_d != ST_RESET) begin
      fnPending_q <= 1'b0;
    end
  end

  // limp and aux settings; forced set wins over a host write in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      limpCtl_q <= 1'b0;
      auxCtl_q <= AUX_CTL_SAFE;
    end else if (state_q == ST_OVERLOAD || state_q == ST_FSP) begin
      limpCtl_q <= 1'b1;
      if (state_q == ST_FSP) begin
        auxCtl_q <= AUX_CTL_SAFE;
      end
    end else if (cmdValid) begin
      limpCtl_q <= frameData[MC_LIMP_BIT];
      auxCtl_q <= frameData[MC_AUX_BIT];
    end
  end

  // non-volatile configuration; a write here counts as reprogramming
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nvA_q <= NV_A_RESET;
      nvB_q <= NV_B_RESET;
    end else if (nvWrite) begin
      if (frameAddr == ADDR_NV_CONFIG_A) begin
        nvA_q <= frameData;
      end else begin
        nvB_q <= frameData;
      end
    end
  end

  // read answer for the frame just taken; returned in the next frame
  logic [2:0] modeField;
  always_comb begin
    unique case (state_q)
      ST_NORMAL: modeField = MODE_NORMAL;
      ST_STANDBY: modeField = MODE_STANDBY;
      ST_SLEEP: modeField = MODE_SLEEP;
      default: modeField = MODE_NONE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frameSeen_q <= 1'b0;
      rdTgl_q <= 1'b0;
      rdData_q <= 8'h00;
    end else if (frameEv) begin
      frameSeen_q <= frameTglS;
      rdTgl_q <= frameTglS;
      if (!rdOk) begin
        rdData_q <= 8'h00;
      end else begin
        unique case (frameAddr)
          ADDR_MODE_CTRL: rdData_q <= {2'h0, auxCtl_q, limpCtl_q, 1'b0, modeField};
          ADDR_MAIN_STATUS: rdData_q <= {2'h0, rcnt_q, limpCtl_q, state_q};
          ADDR_WD_STATUS: rdData_q <= watchdogStatus;
          ADDR_RESET_SRC: rdData_q <= {3'h0, rss_q};
          ADDR_NV_CONFIG_A: rdData_q <= nvA_q;
          ADDR_NV_CONFIG_B: rdData_q <= nvB_q;
          ADDR_ID_0: rdData_q <= ID0_VALUE;
          ADDR_ID_1: rdData_q <= ID1_VALUE;
          default: rdData_q <= 8'h00;
        endcase
      end
    end
  end
  assign spiBus.rdData = rdData_q;
  assign spiBus.rdTgl = rdTgl_q;
  assign sdoOe = !csn;

  // early warnings on the rising detector edge, before overload acts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tempWarn_q <= 1'b0;
      ovFlag_q <= 1'b0;
      otWarnIrq <= 1'b0;
      ovWarnIrq <= 1'b0;
    end else begin
      tempWarn_q <= warnS;
      ovFlag_q <= ovS;
      otWarnIrq <= warnS && !tempWarn_q;
      ovWarnIrq <= ovS && !ovFlag_q;
    end
  end

  // per-mode enables, registered one cycle behind the mode
  logic actDone, offOrOvl;
  assign actDone = stateTimer_q >= ACT_T;
  assign offOrOvl = state_q == ST_OFF || state_q == ST_OVERLOAD;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {mainRegEn, auxRegEn, smpsEn, canEn, linEn, batMonEn} <= 6'h00;
      {hvioEn, hvioLsEn, hvioFailSafe, watchdogEn, irqClearAll, irqEnableAll} <= 6'h00;
      busHighZ <= 1'b1;
    end else begin
      mainRegEn <= !offOrOvl && state_q != ST_SLEEP;
      auxRegEn <= isFn || (!offOrOvl && auxCtl_q);
      smpsEn <= !offOrOvl;
      canEn <= isFn || (state_q == ST_NORMAL && actDone);
      linEn <= isFn || (state_q == ST_NORMAL && actDone);
      batMonEn <= state_q == ST_NORMAL && actDone;
      hvioEn <= !offOrOvl && !isFn;
      hvioLsEn <= state_q == ST_NORMAL && actDone;
      hvioFailSafe <= state_q == ST_OVERLOAD;
      busHighZ <= offOrOvl;
      watchdogEn <= state_q == ST_STANDBY || state_q == ST_NORMAL;
      irqClearAll <= state_q == ST_FSP;
      irqEnableAll <= state_q == ST_FSP;
    end
  end

  // open-drain pins: reset low outside the run modes until the reset hold time has passed, limp low when set except in off and forced normal
  assign cpuResetOut = 1'b0;
  assign cpuResetOe = !(state_q == ST_STANDBY || state_q == ST_NORMAL || isFn ||
    (state_q == ST_RESET && stateTimer_q >= HOLD_T));
  assign limpOut = 1'b0;
  assign limpOe = limpCtl_q && state_q != ST_OFF && !isFn;
  assign resetSource = rss_q;

  a_poff_to_off: assert property (@(posedge clk) disable iff (!reset_n)
    powerOff && state_q != ST_OFF |=> state_q == ST_OFF) else $error("no off entry");
  a_off_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_OFF ##1 state_q == ST_OFF |-> !mainRegEn && !smpsEn && busHighZ)
    else $error("supply on in off");
  a_ot_overload: assert property (@(posedge clk) disable iff (!reset_n)
    state_q != ST_OFF && !powerOff && otS |=> state_q == ST_OVERLOAD)
    else $error("overtemp ignored");
  a_illegal_sleep: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_NORMAL && !powerOff && !otS && !ovLong && !extReset && cmdSleep && !sleepOk
    |=> state_q == ST_RESET && rss_q == RSS_ILLEGAL_SLEEP) else $error("bad sleep");
  a_sleep_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    sleepDis && (state_q == ST_STANDBY || state_q == ST_NORMAL) |=> state_q != ST_SLEEP)
    else $error("sleep not blocked");
  a_act_delay: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_NORMAL && stateTimer_q < ACT_T |=> !canEn && !hvioLsEn)
    else $error("early enable");
  a_rst_hold: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_q == ST_RESET) && !ovf_q |-> cpuResetOe [*2]) else $error("hold short");
  a_fsp_effects: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_FSP |=> rcnt_q == 2'h0 && limpCtl_q && irqClearAll)
    else $error("fsp incomplete");
  a_ovl_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_OVERLOAD |=> !smpsEn && !mainRegEn && hvioFailSafe && limpCtl_q)
    else $error("overload outputs");
  a_fn_no_reset: assert property (@(posedge clk) disable iff (!reset_n)
    isFn && !nvWrite && !powerOff && !otS && !ovLong |=> isFn && !cpuResetOe)
    else $error("forced normal left");
endmodule

// ==== src/ssc_pkg.sv ====
package ssc_pkg;
  // clock rate and the time figures that the counters are built from
  localparam int CLK_MHZ = 250;
  localparam int RST_HOLD_US = 20;
  localparam int ACT_DELAY_US = 5;
  localparam int OV_DET_US = 10;
  localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
  localparam int ACT_DELAY_CYC = ACT_DELAY_US * CLK_MHZ;
  localparam int OV_DET_CYC = OV_DET_US * CLK_MHZ;
  localparam int TIMER_W = 16;

  // register addresses on the serial port (7-bit)
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
  localparam logic [6:0] ADDR_WD_STATUS = 7'h05;
  localparam logic [6:0] ADDR_RESET_SRC = 7'h0a;
  localparam logic [6:0] ADDR_NV_CONFIG_A = 7'h70;
  localparam logic [6:0] ADDR_NV_CONFIG_B = 7'h75;
  localparam logic [6:0] ADDR_ID_0 = 7'h7e;
  localparam logic [6:0] ADDR_ID_1 = 7'h7f;

  // frame layout: address, read-only flag, data byte
  localparam int FRAME_W = 16;
  localparam int FR_ADDR_LSB = 9;
  localparam int FR_RO_BIT = 8;

  // mode_select_field codes and control bit positions
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h4;
  localparam logic [2:0] MODE_NORMAL = 3'h7;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam int MC_LIMP_BIT = 4;
  localparam int MC_AUX_BIT = 5;
  localparam int NVA_SLEEP_DIS_BIT = 0;
  localparam int NVA_FNORMAL_BIT = 1;
  localparam logic AUX_CTL_SAFE = 1'b1;

  // reset_source_field codes
  localparam logic [4:0] RSS_POWER_ON = 5'h00;
  localparam logic [4:0] RSS_EXTERNAL = 5'h01;
  localparam logic [4:0] RSS_OVERLOAD = 5'h02;
  localparam logic [4:0] RSS_WAKE = 5'h03;
  localparam logic [4:0] RSS_FNORMAL_EXIT = 5'h04;
  localparam logic [4:0] RSS_FSP_RETURN = 5'h05;
  localparam logic [4:0] RSS_ILLEGAL_SLEEP = 5'h14;

  localparam logic [1:0] RCC_MAX = 2'h3;
  localparam logic [7:0] READ_STALE = 8'hff;

  // gray along off -> reset -> standby -> normal -> sleep
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RESET = 3'h1,
    ST_STANDBY = 3'h3,
    ST_NORMAL = 3'h2,
    ST_SLEEP = 3'h6,
    ST_OVERLOAD = 3'h7,
    ST_FSP = 3'h5,
    ST_FNORMAL = 3'h4
  } ssc_state_type;
endpackage

// ==== src/ssc_spi_if.sv ====
`timescale 1ns/100ps
interface ssc_spi_if;
  logic [15:0] frameWord;
  logic frameTgl;
  logic [7:0] rdData;
  logic rdTgl;
  modport link (output frameWord, output frameTgl, input rdData, input rdTgl);
  modport core (input frameWord, input frameTgl, output rdData, output rdTgl);
endinterface

// ==== src/ssc_spi_port.sv ====
`timescale 1ns/100ps
module ssc_spi_port import ssc_pkg::*; (
  input wire logic sck,
  input wire logic csn,
  input wire logic reset_n,
  input wire logic sdi,
  output logic sdo,
  ssc_spi_if.link bus
);
  logic [3:0] bitCnt_q;
  logic [14:0] inShift_q;
  logic [7:0] outShift_q;
  logic rdTglS;

  ssc_sync2 #(.WIDTH(1)) uRdSync (.clk(sck), .din(bus.rdTgl), .dout(rdTglS));

  // bit position restarts whenever the select is dropped
  always_ff @(posedge sck or posedge csn) begin
    if (csn) begin
      bitCnt_q <= 4'h0;
    end else begin
      bitCnt_q <= bitCnt_q + 4'h1;
    end
  end

  // receive shifter, msb first
  always_ff @(posedge sck) begin
    inShift_q <= {inShift_q[13:0], sdi};
  end

  // a full frame is published with a toggle; word stays put until the next frame
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      bus.frameWord <= 16'h0000;
      bus.frameTgl <= 1'b0;
    end else if (!csn && bitCnt_q == 4'hf) begin
      bus.frameWord <= {inShift_q, sdi};
      bus.frameTgl <= ~bus.frameTgl;
    end
  end

  // answer of the previous frame goes out in the data byte; stale if not yet back
  always_ff @(posedge sck) begin
    if (bitCnt_q == 4'h7) begin
      outShift_q <= (rdTglS == bus.frameTgl) ? bus.rdData : READ_STALE;
    end else begin
      outShift_q <= {outShift_q[6:0], 1'b0};
    end
  end

  // change on the falling edge so the host samples a settled bit
  always_ff @(negedge sck) begin
    sdo <= outShift_q[7];
  end
endmodule

// ==== src/ssc_sync2.sv ====
`timescale 1ns/100ps
module ssc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end
endmodule

// ==== test/ssc_host_model.sv ====
`timescale 1ns/100ps
// host side of the serial port: sck stands low between frames, 48 ns period
module ssc_host_model (
  output logic sck,
  output logic csn,
  output logic sdi,
  input wire logic sdo,
  output logic rdValid,
  output logic [7:0] rdByte
);
  // the bit counter is cleared only by a rising select, so give it one at start
  initial begin
    sck = 1'b0;
    csn = 1'b0;
    sdi = 1'b1;
    rdValid = 1'b0;
    rdByte = 8'h00;
    #1;
    csn = 1'b1;
  end

  // one whole 16-bit frame; data bits change on sck fall, answer taken on rise
  task automatic xfer(input logic [6:0] a, input logic ro, input logic [7:0] d,
                      input logic chk);
    logic [15:0] w;
    int i;
    w = {a, ro, d};
    csn = 1'b0;
    #24;
    for (i = 15; i >= 0; i--) begin
      sdi = w[i];
      #24;
      sck = 1'b1;
      if (i < 8) begin
        rdByte[i] = sdo;
      end
      #24;
      sck = 1'b0;
    end
    #24;
    csn = 1'b1;
    sdi = ~sdi; // released line: never leave the last bit looking valid
    rdValid = chk;
    #48;
    rdValid = 1'b0;
    #48;
  endtask
endmodule

// ==== test/ssc_mode_controller_tb.sv ====
`timescale 1ns/100ps
module ssc_mode_controller_tb;
  logic clk = 1'b0;
  logic reset_n;
  logic batAbovePon = 1'b0, batBelowPoff = 1'b0, smpsBelowPoff = 1'b0;
  logic tempAboveAct = 1'b0, tempBelowRel = 1'b1, batOverVolt = 1'b0, tempWarn = 1'b0;
  logic resetEvent = 1'b0, wakeEvent = 1'b0, intPending = 1'b0, wakePending = 1'b0;
  logic wakeSrcEnabled = 1'b1;
  logic [7:0] wdStat = 8'h00;
  logic sck, csn, sdi, sdo, cpuResetOe, rdValid;
  logic [7:0] rdByte, expVal;
  logic [7:0] expQ[$];
  string nameQ[$];
  string expName;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 32'h011f;
  // reset line has a pull-up: high whenever the device is not pulling it
  wire cpuResetIn = ~cpuResetOe;

  always #2 clk = ~clk;

  ssc_mode_controller #(.RST_HOLD_CYCLES(20), .ACT_DELAY_CYCLES(10), .OV_DET_CYCLES(8)) dut (
    .clk(clk), .reset_n(reset_n), .sck(sck), .csn(csn), .sdi(sdi), .sdo(sdo), .sdoOe(),
    .batAbovePon(batAbovePon), .batBelowPoff(batBelowPoff), .smpsBelowPoff(smpsBelowPoff),
    .tempAboveAct(tempAboveAct), .tempBelowRel(tempBelowRel), .batOverVolt(batOverVolt),
    .tempWarn(tempWarn), .cpuResetIn(cpuResetIn), .cpuResetOut(), .cpuResetOe(cpuResetOe),
    .resetEvent(resetEvent), .wakeEvent(wakeEvent), .intPending(intPending),
    .wakePending(wakePending), .wakeSrcEnabled(wakeSrcEnabled), .watchdogStatus(wdStat),
    .limpOut(), .limpOe(), .mainRegEn(), .auxRegEn(), .smpsEn(), .canEn(), .linEn(),
    .batMonEn(), .hvioEn(), .hvioLsEn(), .hvioFailSafe(), .busHighZ(), .watchdogEn(),
    .irqClearAll(), .irqEnableAll(), .otWarnIrq(), .ovWarnIrq(), .resetSource());

  ssc_host_model host (.sck(sck), .csn(csn), .sdi(sdi), .sdo(sdo), .rdValid(rdValid),
    .rdByte(rdByte));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(a, 1'b0, d, 1'b0);
    step(10);
  endtask

  // answer of a read comes out in the following frame
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
    expQ.push_back(e);
    nameQ.push_back(nm);
    host.xfer(a, 1'b1, 8'h00, 1'b0);
    step(10);
    host.xfer(7'h03, 1'b1, 8'h00, 1'b1);
    step(10);
  endtask

  // bounded wait for the reset line to be let go, then for standby to settle
  task automatic rstWait;
    int i;
    for (i = 0; i < 200 && cpuResetOe !== 1'b0; i++) begin
      step(1);
    end
    if (cpuResetOe !== 1'b0) begin
      miscompares++;
      $display("FAIL reset release expected 0 seen %b", cpuResetOe);
    end
    step(10);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // each answered read takes the oldest expectation
  always @(posedge rdValid) begin
    if (expQ.size() != 0) begin
      expVal = expQ.pop_front();
      expName = nameQ.pop_front();
      total_checks++;
      if (rdByte !== expVal) begin
        miscompares++;
        $display("FAIL %s expected %h seen %h", expName, expVal, rdByte);
      end
    end
  end

  // a real falling edge, so the link flops see their asynchronous reset
  initial begin
    reset_n <= 1'b0;
    step(8);
    reset_n <= 1'b1;
    step(3);
    wdStat <= 8'($random(seed));
    batAbovePon <= 1'b1;
    step(4);
    rstWait;
    rd(7'h03, 8'h03, "status after power-up");
    rd(7'h7e, 8'h5a, "identification low");
    rd(7'h05, wdStat, "watchdog status");
    $display("test power-up done");
    wr(7'h01, 8'h07);
    rd(7'h03, 8'h02, "status normal");
    wr(7'h01, 8'h04);
    rd(7'h03, 8'h03, "status standby by command");
    $display("test mode commands done");
    wr(7'h70, 8'h01);
    wr(7'h01, 8'h01);
    rd(7'h03, 8'h03, "status sleep disabled");
    wr(7'h70, 8'h00);
    $display("test sleep disable done");
    wr(7'h01, 8'h07);
    intPending <= 1'b1;
    wr(7'h01, 8'h01);
    rstWait;
    rd(7'h0a, 8'h14, "reset source illegal sleep");
    rd(7'h03, 8'h13, "status standby via reset");
    intPending <= 1'b0;
    $display("test illegal sleep done");
    // a hot die is never also below the release threshold
    tempAboveAct <= 1'b1;
    tempBelowRel <= 1'b0;
    step(10);
    rd(7'h03, 8'h1f, "status overload");
    $display("test overload done");
    tempAboveAct <= 1'b0;
    tempBelowRel <= 1'b1;
    rstWait;
    rd(7'h0a, 8'h02, "reset source overload");
    rd(7'h03, 8'h2b, "status standby after overload");
    $display("test overload exit done");
    wr(7'h01, 8'h01);
    rd(7'h03, 8'h26, "status sleep");
    wakeEvent <= 1'b1;
    step(1);
    wakeEvent <= 1'b0;
    rstWait;
    rd(7'h0a, 8'h03, "reset source wake");
    // counter now stands at 3, so this reset overflows into forced prep
    resetEvent <= 1'b1;
    step(1);
    resetEvent <= 1'b0;
    step(10);
    rd(7'h03, 8'h0e, "status sleep via forced prep");
    $display("test sleep and counter overflow done");
    // a dead battery is below the power-on threshold as well
    batBelowPoff <= 1'b1;
    smpsBelowPoff <= 1'b1;
    batAbovePon <= 1'b0;
    step(10);
    rd(7'h03, 8'h08, "status off");
    $display("test power-off done");
    close_out;
  end

  // hang guard, well past the expected run of about 40 us
  initial begin
    #100000;
    miscompares++;
    close_out;
  end
endmodule
